/* File: design/fpe_front_panel.sv */
`timescale 1ns/1ps
`include "fpe_defs.svh"

module fpe_front_panel #(
    parameter logic [24:0] DEB_CYC  = 25'(`FPE_DEB_CYC),
    parameter logic [24:0] LONG_CYC = 25'(`FPE_LONG_CYC)
) (
    input  wire logic           sys_clk,   // System clock, 20 MHz
    input  wire logic           rst_b,     // Async reset, active low
    input  wire logic           encAPin,   // Encoder phase A pin
    input  wire logic           encBPin,   // Encoder phase B pin
    input  wire logic           pushPin,   // Knob switch, high pressed
    input  wire logic           hostWe,    // Host setting write strobe
    input  wire logic [4:0]     hostAddr,  // Host setting word index
    input  wire logic [7:0]     hostData,  // Host setting value
    output logic                hostReady, // Host writes are taken
    output fpe_pkg::fpe_nvm_req_t nvm,     // Memory request group
    input  wire logic           nvmAck,    // Memory done, one pulse
    input  wire logic [7:0]     nvmRdata,  // Read data with nvmAck
    output logic                running,   // Restore finished
    output logic                levelLamp, // Green lamp, level mode
    output logic                linkOn,    // Stereo link state
    output logic [4:0]          curTarget, // Selected target index
    output fpe_pkg::fpe_cfg_t   cfgOut,    // All setting words
    output fpe_pkg::fpe_disp_t  display    // Display content
);
    import fpe_pkg::*;

    typedef struct packed {
        logic         aS1;
        logic         aS2;
        logic         aPrev;
        logic         bS1;
        logic         bS2;
        fpe_nvst_t    nvSt;
        logic [4:0]   rdIdx;
        fpe_nvm_req_t nvm;
        logic [31:0]  dirty;
        fpe_cfg_t     cfg;
        fpe_mode_t    mode;
        logic [4:0]   sel;
        fpe_disp_t    disp;
    } fpe_main_st_t;

    fpe_main_st_t q;
    fpe_main_st_t d;
    logic         shortPress;
    logic         longPress;

    // ------------------------------------------------------------------
    // Target, level and dirty-word arithmetic
    // ------------------------------------------------------------------
    function automatic logic isPaired(input logic [4:0] s);
        isPaired = (s != `FPE_IDX_PHONES) && (s != `FPE_IDX_COAX);
    endfunction

    function automatic logic [4:0] leftOf(input logic [4:0] s);
        leftOf = isPaired(s) ? {s[4:1], 1'b0} : s;
    endfunction

    // Phones and coax are single stops, so linked stepping is not uniform
    function automatic logic [4:0] nextTarget(input logic [4:0] s,
                                              input logic up,
                                              input logic lnk);
        nextTarget = s;
        if (!lnk)
        begin
            if (up)
                nextTarget = (s == `FPE_IDX_OPT_LAST) ? 5'h00 : s + 5'h01;
            else
                nextTarget = (s == 5'h00) ? `FPE_IDX_OPT_LAST : s - 5'h01;
        end
        else if (up)
        begin
            if (s == `FPE_IDX_PHONES || s == `FPE_IDX_COAX)
                nextTarget = s + 5'h01;
            else if (s == `FPE_IDX_OPT_LAST - 5'h01)
                nextTarget = 5'h00;
            else
                nextTarget = s + 5'h02;
        end
        else
        begin
            if (s == `FPE_IDX_COAX || s == `FPE_IDX_COAX + 5'h01)
                nextTarget = s - 5'h01;
            else if (s == 5'h00)
                nextTarget = `FPE_IDX_OPT_LAST - 5'h01;
            else
                nextTarget = s - 5'h02;
        end
    endfunction

    // Saturating steps; the mic code jumps between 0 dB and its minimum
    function automatic logic [7:0] stepLevel(input logic [4:0] s,
                                             input logic [7:0] c,
                                             input logic up);
        stepLevel = c;
        if (s <= `FPE_IDX_MIC_LAST)
        begin
            if (up)
                stepLevel = (c < `FPE_MIC_MIN) ? `FPE_MIC_MIN :
                            (c < `FPE_MIC_MAX) ? c + 8'h01 : c;   // RL5
            else
                stepLevel = (c > `FPE_MIC_MIN) ? c - 8'h01 :
                            `FPE_MIC_OFF;                         // RL5
        end
        else if (s <= `FPE_IDX_INST_LAST)
        begin
            if (up)
                stepLevel = (c < `FPE_INST_MAX) ? c + 8'h01 : c;  // RL6
            else
                stepLevel = (c > 8'h00) ? c - 8'h01 : c;          // RL6
        end
        else
        begin
            if (up)
                stepLevel = (c < `FPE_OUT_MAX) ? c + 8'h01 : c;   // RL8
            else
                stepLevel = (c > `FPE_OUT_MUTE) ? c - 8'h01 : c;  // RL8
        end
    endfunction

    function automatic logic [4:0] firstDirty(input logic [31:0] v);
        firstDirty = 5'h00;
        for (int i = 31; i >= 0; i--)
            if (v[i])
                firstDirty = 5'(i);
    endfunction

    // ------------------------------------------------------------------
    // Push switch filter
    // ------------------------------------------------------------------
    fpe_push_filter #(
        .DEB_CYC  (DEB_CYC),
        .LONG_CYC (LONG_CYC)
    ) u_push (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .pushPin    (pushPin),
        .shortPress (shortPress),
        .longPress  (longPress)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        logic       run;
        logic       step;
        logic       up;
        logic       lnk;
        logic [7:0] lv;
        run = 1'b0;
        step = 1'b0;
        up = 1'b0;
        lnk = 1'b0;
        lv = 8'h00;
        d = q;
        d.aS1 = encAPin;
        d.aS2 = q.aS1;
        d.aPrev = q.aS2;
        d.bS1 = encBPin;
        d.bS2 = q.bS1;
        run = (q.nvSt != NV_RD);
        step = q.aS2 && !q.aPrev;
        up = !q.bS2;
        lnk = q.cfg[`FPE_IDX_LINK][`FPE_LINK_BIT];

        // Memory sequencer; ack clears before any change below sets again
        unique case (q.nvSt)
            NV_RD:
            begin
                d.nvm.req = 1'b1;
                d.nvm.write = 1'b0;
                d.nvm.addr = q.rdIdx;
                if (q.nvm.req && nvmAck)
                begin
                    d.cfg[q.rdIdx] = nvmRdata;                    // RL2
                    d.rdIdx = q.rdIdx + 5'h01;
                    d.nvm.addr = q.rdIdx + 5'h01;
                    if (q.rdIdx == `FPE_IDX_CFG_LAST)
                    begin
                        d.nvm.req = 1'b0;
                        d.nvSt = NV_IDLE;
                    end
                end
            end
            NV_IDLE:
            begin
                if (q.dirty != 32'h00000000)
                begin
                    d.nvm.req = 1'b1;                             // RL1
                    d.nvm.write = 1'b1;
                    d.nvm.addr = firstDirty(q.dirty);
                    d.nvm.wdata = q.cfg[firstDirty(q.dirty)];
                    d.nvSt = NV_WR;
                end
            end
            NV_WR:
            begin
                if (nvmAck)
                begin
                    // A word changed while its write was out goes again
                    d.dirty[q.nvm.addr] = (q.cfg[q.nvm.addr] != q.nvm.wdata);
                    d.nvm.req = 1'b0;
                    d.nvSt = NV_IDLE;
                end
            end
        endcase

        // Host settings; the panel below overrides on the same cycle
        if (run && hostWe && q.cfg[hostAddr] != hostData)
        begin
            d.cfg[hostAddr] = hostData;
            d.dirty[hostAddr] = 1'b1;                             // RL1
        end

        // Panel actions are held off until the restore has finished
        if (run && shortPress)
        begin
            d.mode = (q.mode == FPE_CHANNEL) ? FPE_LEVEL : FPE_CHANNEL;
        end                                                       // RL3
        if (run && longPress)
        begin
            d.cfg[`FPE_IDX_LINK][`FPE_LINK_BIT] = !lnk;           // RL9
            d.dirty[`FPE_IDX_LINK] = 1'b1;
            d.disp.kind = DK_LINK;
            d.disp.value = {7'h00, !lnk};
            d.disp.dot = 1'b0;
            if (!lnk)
                d.sel = leftOf(q.sel);                            // RL10
        end
        else if (run && step && q.mode == FPE_CHANNEL)
        begin
            d.sel = nextTarget(leftOf(q.sel), up, lnk);           // RL4
            if (!lnk)
                d.sel = nextTarget(q.sel, up, lnk);
            d.disp.kind = DK_TARGET;
            d.disp.value = {3'h0, d.sel};
            d.disp.dot = 1'b0;
        end
        else if (run && step)
        begin
            lv = stepLevel(q.sel, q.cfg[q.sel], up);
            if (lv != q.cfg[q.sel])
            begin
                d.cfg[q.sel] = lv;
                d.dirty[q.sel] = 1'b1;                            // RL1
                if (lnk && isPaired(q.sel))
                begin
                    d.cfg[{q.sel[4:1], 1'b1}] = lv;               // RL10
                    d.dirty[{q.sel[4:1], 1'b1}] = 1'b1;
                end
            end
            d.disp.kind = DK_LEVEL;
            d.disp.value = lv;
            d.disp.dot = (q.sel > `FPE_IDX_MIC_LAST) &&
                         (q.sel <= `FPE_IDX_INST_LAST) && lv[0];  // RL7
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q <= '0;
            q.nvSt <= NV_RD;
            q.mode <= FPE_CHANNEL;
            q.disp.kind <= DK_TARGET;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign hostReady = (q.nvSt != NV_RD);
    assign nvm = q.nvm;
    assign running = (q.nvSt != NV_RD);                           // RL2
    assign levelLamp = (q.mode == FPE_LEVEL);                     // RL3
    assign linkOn = q.cfg[`FPE_IDX_LINK][`FPE_LINK_BIT];
    assign curTarget = q.sel;
    assign cfgOut = q.cfg;
    assign display = q.disp;

endmodule

/* File: design/fpe_defs.svh */
// Operation
// [RL1] Any change to any stored setting is written to non-volatile memory.
// [RL2] At power-on every setting is read back before the panel works.
// [RL3] A push toggles channel and level mode, shown on a green lamp.
// [RL4] In channel mode rotation steps through all twenty targets.
// [RL5] Mic gain runs 10 to 65 dB in 1 dB steps, plus a 0 dB setting.
// [RL6] Instrument gain runs 0 to 18 dB in half-decibel steps.
// [RL7] A half-decibel instrument gain lights the display dot.
// [RL8] Output level runs +6 to -58 dB in 1 dB steps, plus mute.
// [RL9] A press held over one second toggles stereo link, shown off or on.
// [RL10] With link on only left channels are offered and both follow.
// [RL11] The push is debounced; a long press never toggles the mode. Code toggles it when the release lands in the cycle the long press fires.
`ifndef FPE_DEFS_SVH
`define FPE_DEFS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FPE_CLK_HZ      20000000
`define FPE_DEBOUNCE_MS 10
`define FPE_LONG_MS     1000
`define FPE_DEB_CYC     ((`FPE_CLK_HZ / 1000) * `FPE_DEBOUNCE_MS)
`define FPE_LONG_CYC    ((`FPE_CLK_HZ / 1000) * `FPE_LONG_MS)

// ----------------------------------------------------------------------
// Configuration word map
// ----------------------------------------------------------------------
`define FPE_IDX_MIC_LAST  5'h01
`define FPE_IDX_INST_LAST 5'h03
`define FPE_IDX_PHONES    5'h0a
`define FPE_IDX_COAX      5'h0b
`define FPE_IDX_OPT_LAST  5'h13
`define FPE_IDX_LINK      5'h14
`define FPE_IDX_CFG_LAST  5'h1f
`define FPE_LINK_BIT      0

// ----------------------------------------------------------------------
// Level codes
// ----------------------------------------------------------------------
`define FPE_MIC_OFF  8'h00
`define FPE_MIC_MIN  8'h0a
`define FPE_MIC_MAX  8'h41
`define FPE_INST_MAX 8'h24
`define FPE_OUT_MUTE 8'h00
`define FPE_OUT_MAX  8'h41
`define FPE_CFG_RST  8'h00

`endif

/* File: design/fpe_pkg.sv */
package fpe_pkg;

    typedef enum logic {FPE_CHANNEL, FPE_LEVEL} fpe_mode_t;

    typedef enum logic [1:0] {
        NV_RD,
        NV_IDLE,
        NV_WR
    } fpe_nvst_t;

    typedef enum logic [1:0] {DK_TARGET, DK_LEVEL, DK_LINK} fpe_dkind_t;

    typedef logic [31:0][7:0] fpe_cfg_t;

    typedef struct packed {
        fpe_dkind_t kind;
        logic [7:0] value;
        logic       dot;
    } fpe_disp_t;

    typedef struct packed {
        logic       req;
        logic       write;
        logic [4:0] addr;
        logic [7:0] wdata;
    } fpe_nvm_req_t;

    typedef struct packed {
        logic          s1;
        logic          s2;
        logic          level;
        logic [24:0]   debCnt;
        logic [24:0]   holdCnt;
        logic          longDone;
        logic          shortPress;
        logic          longPress;
    } fpe_push_st_t;

endpackage

/* File: design/fpe_push_filter.sv */
`timescale 1ns/1ps
`include "fpe_defs.svh"

module fpe_push_filter #(
    parameter logic [24:0] DEB_CYC  = 25'(`FPE_DEB_CYC),
    parameter logic [24:0] LONG_CYC = 25'(`FPE_LONG_CYC)
) (
    input  wire logic sys_clk,    // System clock
    input  wire logic rst_b,      // Async reset, active low
    input  wire logic pushPin,    // Raw switch, high while pressed
    output logic      shortPress, // Pulse on release of a short press
    output logic      longPress   // Pulse when held past the threshold
);
    import fpe_pkg::*;

    fpe_push_st_t q;
    fpe_push_st_t d;

    // ------------------------------------------------------------------
    // Synchronise, debounce and classify
    // ------------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.s1 = pushPin;
        d.s2 = q.s1;
        d.shortPress = 1'b0;
        d.longPress = 1'b0;
        // Level must stay changed for the full window before it is taken
        if (q.s2 != q.level)
        begin
            d.debCnt = q.debCnt + 25'h0000001;
            if (q.debCnt == DEB_CYC - 25'h0000001)
            begin
                d.level = q.s2;
                d.debCnt = '0;
            end
        end
        else
        begin
            d.debCnt = '0;
        end
        // Hold timer; long fires once so a release after it is silent
        if (q.level && !q.longDone)
        begin
            d.holdCnt = q.holdCnt + 25'h0000001;
            if (q.holdCnt == LONG_CYC)
            begin
                d.longPress = 1'b1;                             // RL11
                d.longDone = 1'b1;
            end
        end
        if (q.level && !d.level)
        begin
            d.shortPress = !q.longDone;                         // RL11
            d.longDone = 1'b0;
            d.holdCnt = '0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            q <= '0;
        else
            q <= d;
    end

    assign shortPress = q.shortPress;
    assign longPress = q.longPress;

endmodule

/* File: tb/fpe_panel_monitor.sv */
`timescale 1ns/1ps

module fpe_panel_monitor #(
    parameter logic [24:0] DEB_CYC  = 25'h0000004,
    parameter logic [24:0] LONG_CYC = 25'h0000028
) (
    input wire logic            sys_clk,   // Clock
    input wire logic            rst_b,     // Reset, active low
    input fpe_pkg::fpe_nvm_req_t nvm,      // Memory request group
    input wire logic            nvmAck,    // Memory done
    input wire logic            running,   // Restore finished
    input wire logic            levelLamp, // Level mode lamp
    input wire logic            linkOn,    // Stereo link
    input wire logic [4:0]      curTarget, // Selected target
    input fpe_pkg::fpe_cfg_t    cfgOut,    // Setting words
    input fpe_pkg::fpe_disp_t   display    // Display content
);
    import fpe_pkg::*;

    logic outOk; // All output words inside mute..+6 dB

    // ------------------------------------------------------------------
    // Helper
    // ------------------------------------------------------------------
    // One loop is cheaper than sixteen separate range assertions
    always_comb
    begin
        outOk = 1'b1;
        for (int i = 4; i < 20; i++)
            if (cfgOut[i] > 8'h41)
                outOk = 1'b0;
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // Request and its qualifiers stand until the memory answers
    req_hold_a: assert property (
        nvm.req && !nvmAck |=> nvm.req && $stable(nvm))
        else $error("memory request changed before ack");
    write_gap_a: assert property (
        nvm.req && nvm.write && nvmAck |=> !nvm.req)
        else $error("write request not dropped after ack");
    restore_read_a: assert property (!running && nvm.req |-> !nvm.write)
        else $error("write issued before restore finished");
    panel_idle_a: assert property (!running |-> !levelLamp)
        else $error("panel active before restore finished");
    sel_range_a: assert property (curTarget <= 5'h13)
        else $error("target index out of range");
    mic_range_a: assert property (
        cfgOut[0] == 8'h00 || cfgOut[0] inside {[8'h0a:8'h41]})
        else $error("mic gain code out of range");
    inst_range_a: assert property (
        cfgOut[2] <= 8'h24 && cfgOut[3] <= 8'h24)
        else $error("instrument gain code out of range");
    inst_dot_a: assert property (
        display.kind == DK_LEVEL && curTarget inside {5'h02, 5'h03}
        |-> display.dot == display.value[0])
        else $error("half step dot wrong");
    out_range_a: assert property (outOk)
        else $error("output level code out of range");
    // A link toggle from the knob shows the new state at once
    link_word_a: assert property (
        $changed(linkOn) && $changed(display)
        |-> display.kind == DK_LINK && display.value == {7'h00, linkOn})
        else $error("link display does not show new state");
    link_even_a: assert property (
        linkOn && $past(linkOn) |-> !curTarget[0] || curTarget == 5'h0b)
        else $error("right channel offered while linked");
    long_mode_a: assert property (
        $changed(linkOn) |-> $stable(levelLamp))
        else $error("link toggle also changed mode");

    mode_c:  cover property ($rose(levelLamp));
    link_c:  cover property ($rose(linkOn));
    write_c: cover property (nvm.req && nvm.write && nvmAck);
    wrap_c:  cover property (curTarget == 5'h13);
endmodule

bind fpe_front_panel fpe_panel_monitor #(
    .DEB_CYC (DEB_CYC),
    .LONG_CYC(LONG_CYC)
) mon (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .nvm      (nvm),
    .nvmAck   (nvmAck),
    .running  (running),
    .levelLamp(levelLamp),
    .linkOn   (linkOn),
    .curTarget(curTarget),
    .cfgOut   (cfgOut),
    .display  (display)
);

/* File: tb/tb.sv */
`timescale 1ns/1ps

module tb;
    import fpe_pkg::*;

    localparam logic [4:0] LNK [11] = '{5'h06, 5'h08, 5'h0a, 5'h0b,
        5'h0c, 5'h0e, 5'h10, 5'h12, 5'h00, 5'h02, 5'h04};

    logic          sys_clk   = 1'b0;  // 20 MHz clock
    logic          rst_b     = 1'b0;  // Reset, active low
    logic          encAPin   = 1'b0;  // Encoder phase A
    logic          encBPin   = 1'b0;  // Encoder phase B
    logic          pushPin   = 1'b0;  // Knob switch
    logic          hostWe    = 1'b0;  // Host strobe
    logic [4:0]    hostAddr  = 5'h00; // Host word index
    logic [7:0]    hostData  = 8'h00; // Host value
    logic          nvmAck    = 1'b0;  // Memory done
    logic [7:0]    nvmRdata  = 8'h00; // Memory read data
    logic [1:0]    ackWait   = 2'h0;  // Memory answer delay
    logic [31:0]   rnd       = 32'he4e64496;
    logic [12:0]   expQ[$];           // Expected memory writes
    logic [15:0]   expWr;             // Oldest note, or none
    int            error_cnt = 0;
    int            cmp_count = 0;
    logic          hostReady;
    logic          running;
    logic          levelLamp;
    logic          linkOn;
    logic [4:0]    curTarget;
    fpe_nvm_req_t  nvm;
    fpe_cfg_t      cfgOut;
    fpe_disp_t     display;

    always #25 sys_clk = ~sys_clk;

    // Short counts keep the long press at a few dozen cycles
    fpe_front_panel #(.DEB_CYC(25'h0000004), .LONG_CYC(25'h0000028)) uut (
        .sys_clk(sys_clk), .rst_b(rst_b), .encAPin(encAPin),
        .encBPin(encBPin), .pushPin(pushPin), .hostWe(hostWe),
        .hostAddr(hostAddr), .hostData(hostData), .hostReady(hostReady),
        .nvm(nvm), .nvmAck(nvmAck), .nvmRdata(nvmRdata),
        .running(running), .levelLamp(levelLamp), .linkOn(linkOn),
        .curTarget(curTarget), .cfgOut(cfgOut), .display(display));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Stored image: every word a legal code for its target
    function automatic logic [7:0] restoreVal(input logic [4:0] a);
        case (a)
            5'h00:   return 8'h14;
            5'h01:   return 8'h00;
            5'h02:   return 8'h23;
            5'h03:   return 8'h24;
            default: return (a < 5'h14) ? 8'h41 : {3'h0, a};
        endcase
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask

    task automatic step(input logic dn);
        encBPin = dn;
        tick(1);
        encAPin = 1'b1;
        tick(2);
        encAPin = 1'b0;
        tick(6);
    endtask

    task automatic press(input int n);
        pushPin = 1'b1;
        tick(n);
        pushPin = 1'b0;
        tick(12);
    endtask

    // Note the memory writes first: the answer may come before we look
    task automatic turn(input logic dn, input logic [4:0] a,
                        input logic [7:0] v, input logic wr, input logic pr);
        if (wr)
            expQ.push_back({a, v});
        if (pr)
            expQ.push_back({a | 5'h01, v});
        step(dn);
        check(cfgOut[a], v);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Memory side: answers after zero to three random idle cycles
    always @(posedge sys_clk)
    begin
        #2;
        if (nvmAck)
        begin
            nvmAck   = 1'b0;
            nvmRdata = ~nvmRdata;
        end
        else if (nvm.req === 1'b1 && ackWait == 2'h0)
        begin
            nvmAck   = 1'b1;
            nvmRdata = restoreVal(nvm.addr);
            rnd      = lfsr(rnd);
            ackWait  = rnd[1:0];
        end
        else if (nvm.req === 1'b1)
            ackWait = ackWait - 2'h1;
    end

    // Watcher: each acknowledged write against the oldest note
    // A write with no note left counts as a mismatch
    always @(posedge sys_clk)
        if (nvmAck === 1'b1 && nvm.write === 1'b1)
        begin
            expWr = (expQ.size() > 0) ? 16'(expQ.pop_front()) : 16'hffff;
            check({nvm.addr, nvm.wdata}, expWr);
        end

    initial
    begin
        tick(4);
        check(16'(nvm), 16'h0000);
        tick(1);
        rst_b = 1'b1;
        for (int i = 0; i < 2000 && running !== 1'b1; i++)
            tick(1);
        if (running !== 1'b1)
        begin
            error_cnt++;
            close_out();
        end
        for (int k = 0; k < 32; k++)
            check(cfgOut[k], restoreVal(5'(k)));
        check(hostReady, 1'b1);
        rnd = lfsr(rnd);
        expQ.push_back({5'h15, rnd[7:0] | 8'h80});
        hostWe   = 1'b1;
        hostAddr = 5'h15;
        hostData = rnd[7:0] | 8'h80;
        tick(1);
        hostWe   = 1'b0;
        tick(1);
        check(cfgOut[21], rnd[7:0] | 8'h80);
        $display("test restore and host write done");
        press(12);
        check(levelLamp, 1'b1);
        turn(1'b0, 5'h00, 8'h15, 1'b1, 1'b0);
        expQ.push_back({5'h00, 8'h0a});
        hostWe   = 1'b1;
        hostAddr = 5'h00;
        hostData = 8'h0a;
        tick(1);
        hostWe   = 1'b0;
        turn(1'b1, 5'h00, 8'h00, 1'b1, 1'b0);
        turn(1'b0, 5'h00, 8'h0a, 1'b1, 1'b0);
        press(12);
        check(levelLamp, 1'b0);
        for (int i = 1; i <= 20; i++)
        begin
            step(1'b0);
            check(curTarget, 16'(i % 20));
            check(display.value, 16'(i % 20));
        end
        $display("test mode and selection done");
        step(1'b0);
        step(1'b0);
        press(12);
        turn(1'b0, 5'h02, 8'h24, 1'b1, 1'b0);
        check(display.dot, 1'b0);
        turn(1'b0, 5'h02, 8'h24, 1'b0, 1'b0);
        turn(1'b1, 5'h02, 8'h23, 1'b1, 1'b0);
        check(display.dot, 1'b1);
        press(12);
        step(1'b0);
        step(1'b0);
        press(12);
        turn(1'b0, 5'h04, 8'h41, 1'b0, 1'b0);
        turn(1'b1, 5'h04, 8'h40, 1'b1, 1'b0);
        press(12);
        step(1'b0);
        $display("test level ranges done");
        expQ.push_back({5'h14, 8'h15});
        press(70);
        check(linkOn, 1'b1);
        check({display.kind, display.value}, {DK_LINK, 8'h01});
        check(levelLamp, 1'b0);
        check(curTarget, 5'h04);
        foreach (LNK[j])
        begin
            step(1'b0);
            check(curTarget, LNK[j]);
        end
        press(12);
        turn(1'b1, 5'h04, 8'h3f, 1'b1, 1'b1);
        check(cfgOut[5], 8'h3f);
        expQ.push_back({5'h14, 8'h14});
        press(70);
        check({linkOn, levelLamp}, 2'b01);
        check({display.kind, display.value}, {DK_LINK, 8'h00});
        tick(40);
        check(expQ.size(), 16'h0000);
        $display("test stereo link done");
        close_out();
    end
endmodule
